// *** src/stiu_map.svh ***
// Register offsets, field positions, reset values and bus codes of the skip/test unit
`ifndef STIU_MAP_SVH
`define STIU_MAP_SVH

`define STIU_ADDR_CTRL_A     8'h00
`define STIU_ADDR_CTRL_B     8'h04
`define STIU_ADDR_PORT_IDX   8'h08
`define STIU_ADDR_PORT_D     8'h0C
`define STIU_ADDR_IRQ_STAT   8'h10
`define STIU_ADDR_IRQ_MASK   8'h14
`define STIU_ADDR_FLAGS      8'h18

`define STIU_EXT0_MASK_POS   0
`define STIU_PIN_POL_POS     2

`define STIU_EV_SKIP_POS     0
`define STIU_EV_EXT0_POS     1
`define STIU_EV_PORT_POS     2
`define STIU_EV_WIDTH        3

`define STIU_FLG_EXT0_POS    0
`define STIU_FLG_SKIP_POS    1
`define STIU_FLG_PIN_POS     2
`define STIU_FLG_STBY_POS    3

`define STIU_CTRL_RESET      4'h0
`define STIU_IDX_RESET       3'h0
`define STIU_RESP_OKAY       2'h0
`define STIU_RESP_SLVERR     2'h2

`endif

// *** src/stiu_pkg.sv ***
// Types shared by the skip/test instruction unit
package stiu_pkg;

   typedef enum logic [2:0]
   {
      STIU_OP_NONE     = 3'b000,
      STIU_OP_SET_PORT = 3'b001,
      STIU_OP_SEQ_IMM  = 3'b010,
      STIU_OP_SEQ_MEM  = 3'b011,
      STIU_OP_TST_EXT0 = 3'b100,
      STIU_OP_TST_PIN  = 3'b101,
      STIU_OP_TST_PD   = 3'b110
   } stiu_op_type;

   typedef struct packed
   {
      stiu_op_type op;
      logic [3:0]  imm;
      logic [3:0]  acc;
      logic [3:0]  mem;
   } stiu_instr_type;

   typedef enum logic [1:0]
   {
      STIU_RD_IDLE = 2'b00,
      STIU_RD_RESP = 2'b01
   } stiu_rd_state_type;

endpackage : stiu_pkg

// *** src/stiu_unit.sv ***
// Skip/test instruction unit with AXI4-Lite control registers
//
// What this block does
// RQ1: set_port_d_bit drives high only port D bit selected by index register, 0..7.
// RQ2: skip_equal_immediate skips next instruction when accumulator equals 4-bit immediate.
// RQ3: skip_equal_memory skips next instruction when accumulator equals memory nibble.
// RQ4: With mask bit 0, test_ext0_request on set flag clears it and skips.
// RQ5: ext0_skip_mask_bit sits at bit 0 of interrupt_control_a.
// RQ6: With mask bit 1, test_ext0_request is a no-operation, flag untouched.
// RQ7: Polarity 0: test_ext0_pin_level skips when interrupt pin is low.
// RQ8: Polarity 1: test_ext0_pin_level skips when interrupt pin is high.
// RQ9: pin_polarity_select sits at bit 2 of interrupt_control_b.
// RQ10: test_powerdown_flag skips next instruction when standby_flag is 1.
// RQ11: Skipped instruction is fetched but changes nothing; sequencer advances past it.
`timescale 1ns/1ps
`include "stiu_map.svh"

module stiu_unit #(
   parameter int PORT_BITS = 8
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic [7:0]             s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [7:0]             s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   input  wire logic                   instr_valid,
   input  wire stiu_pkg::stiu_instr_type instr,
   input  wire logic                   ext0_request_set,
   input  wire logic                   standby_flag,
   input  wire logic                   external_interrupt_pin,
   output logic                        skip_next,
   output logic                        instr_squash,
   output logic                        ext0_request_flag,
   output logic [PORT_BITS-1:0]        port_d_out,
   output logic                        irq
);

   if (PORT_BITS < 2 || PORT_BITS > 8)
   begin : g_bad_width
      $error("PORT_BITS must lie between 2 and 8");
   end

   // Returns register index 0..6, or 7 for an unmapped offset
   function automatic logic [2:0] reg_sel(input logic [7:0] addr);
      if (addr == `STIU_ADDR_CTRL_A) reg_sel = 3'h0;
      else if (addr == `STIU_ADDR_CTRL_B) reg_sel = 3'h1;
      else if (addr == `STIU_ADDR_PORT_IDX) reg_sel = 3'h2;
      else if (addr == `STIU_ADDR_PORT_D) reg_sel = 3'h3;
      else if (addr == `STIU_ADDR_IRQ_STAT) reg_sel = 3'h4;
      else if (addr == `STIU_ADDR_IRQ_MASK) reg_sel = 3'h5;
      else if (addr == `STIU_ADDR_FLAGS) reg_sel = 3'h6;
      else reg_sel = 3'h7;
   endfunction : reg_sel

   // Pin synchroniser; only the second stage is read
   logic pin_meta_reg;
   logic pin_sync_reg;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pin_meta_reg <= 1'b0;
         pin_sync_reg <= 1'b0;
      end
      else
      begin
         pin_meta_reg <= external_interrupt_pin;
         pin_sync_reg <= pin_meta_reg;
      end
   end

   // Register state
   logic [3:0]                ctrl_a_reg, ctrl_a_next;
   logic [3:0]                ctrl_b_reg, ctrl_b_next;
   logic [2:0]                idx_reg, idx_next;
   logic [PORT_BITS-1:0]      port_reg, port_next;
   logic [`STIU_EV_WIDTH-1:0] stat_reg, stat_next;
   logic [`STIU_EV_WIDTH-1:0] mask_reg, mask_next;
   logic                      ext0_reg, ext0_next;
   logic                      skip_reg, skip_next_val;
   logic                      aw_have_reg, aw_have_next;
   logic                      w_have_reg, w_have_next;
   logic [7:0]                aw_addr_reg, aw_addr_next;
   logic [31:0]               w_data_reg, w_data_next;
   logic [3:0]                w_strb_reg, w_strb_next;
   logic                      bvalid_reg, bvalid_next;
   logic [1:0]                bresp_reg, bresp_next;
   stiu_pkg::stiu_rd_state_type rd_state_reg, rd_state_next;
   logic [31:0]               rdata_reg, rdata_next;
   logic [1:0]                rresp_reg, rresp_next;

   logic                      exec;
   logic                      skip_cond;
   logic                      ext0_clear;
   logic                      port_set;
   logic [`STIU_EV_WIDTH-1:0] events;
   logic                      wr_fire;
   logic [2:0]                wr_sel;
   logic [31:0]               rd_word;

   // Squash the instruction that follows a taken skip
   assign instr_squash = instr_valid & skip_reg; // RQ11
   assign exec         = instr_valid & ~skip_reg; // RQ11

   always_comb
   begin
      skip_cond  = 1'b0;
      ext0_clear = 1'b0;
      port_set   = 1'b0;
      if (exec)
      begin
         case (instr.op)
            stiu_pkg::STIU_OP_SET_PORT: port_set = 1'b1; // RQ1
            stiu_pkg::STIU_OP_SEQ_IMM:  skip_cond = (instr.acc == instr.imm); // RQ2
            stiu_pkg::STIU_OP_SEQ_MEM:  skip_cond = (instr.acc == instr.mem); // RQ3
            stiu_pkg::STIU_OP_TST_EXT0:
            begin
               // Masked test leaves flag and flow alone
               if (!ctrl_a_reg[`STIU_EXT0_MASK_POS] && ext0_reg) // RQ4 RQ5 RQ6
               begin
                  skip_cond  = 1'b1;
                  ext0_clear = 1'b1;
               end
            end
            stiu_pkg::STIU_OP_TST_PIN:
               skip_cond = (pin_sync_reg == ctrl_b_reg[`STIU_PIN_POL_POS]); // RQ7 RQ8 RQ9
            stiu_pkg::STIU_OP_TST_PD:   skip_cond = standby_flag; // RQ10
            default:                    skip_cond = 1'b0;
         endcase
      end
   end

   assign events[`STIU_EV_SKIP_POS] = skip_cond;
   assign events[`STIU_EV_EXT0_POS] = ext0_clear;
   assign events[`STIU_EV_PORT_POS] = port_set;

   assign wr_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
   assign wr_sel  = reg_sel(aw_addr_reg);

   // Write channel and register next values
   always_comb
   begin
      aw_have_next = aw_have_reg;
      w_have_next  = w_have_reg;
      aw_addr_next = aw_addr_reg;
      w_data_next  = w_data_reg;
      w_strb_next  = w_strb_reg;
      bvalid_next  = bvalid_reg;
      bresp_next   = bresp_reg;
      ctrl_a_next  = ctrl_a_reg;
      ctrl_b_next  = ctrl_b_reg;
      idx_next     = idx_reg;
      mask_next    = mask_reg;
      stat_next    = stat_reg;
      if (s_axi_awvalid && !aw_have_reg)
      begin
         aw_have_next = 1'b1;
         aw_addr_next = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_reg)
      begin
         w_have_next = 1'b1;
         w_data_next = s_axi_wdata;
         w_strb_next = s_axi_wstrb;
      end
      if (wr_fire)
      begin
         aw_have_next = 1'b0;
         w_have_next  = 1'b0;
         bvalid_next  = 1'b1;
         bresp_next   = (wr_sel == 3'h7) ? `STIU_RESP_SLVERR : `STIU_RESP_OKAY;
         if (w_strb_reg[0])
         begin
            if (wr_sel == 3'h0) ctrl_a_next = w_data_reg[3:0];
            else if (wr_sel == 3'h1) ctrl_b_next = w_data_reg[3:0];
            else if (wr_sel == 3'h2) idx_next = w_data_reg[2:0];
            else if (wr_sel == 3'h4) stat_next = stat_reg & ~w_data_reg[`STIU_EV_WIDTH-1:0];
            else if (wr_sel == 3'h5) mask_next = w_data_reg[`STIU_EV_WIDTH-1:0];
         end
      end
      else if (bvalid_reg && s_axi_bready)
      begin
         bvalid_next = 1'b0;
      end
      // Set wins over a write-one clear in the same cycle
      stat_next = stat_next | events;
   end

   assign s_axi_awready = ~aw_have_reg;
   assign s_axi_wready  = ~w_have_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;

   // Instruction state next values
   always_comb
   begin
      ext0_next     = ext0_reg;
      skip_next_val = skip_reg;
      if (instr_valid)
      begin
         skip_next_val = skip_cond; // RQ11
      end
      if (ext0_clear)
      begin
         ext0_next = 1'b0; // RQ4
      end
      // A new request outranks the clear by the test
      if (ext0_request_set)
      begin
         ext0_next = 1'b1;
      end
   end

   for (genvar i = 0; i < PORT_BITS; i++)
   begin : g_port
      assign port_next[i] = port_reg[i] | (port_set && idx_reg == 3'(i)); // RQ1
   end

   // Read channel
   always_comb
   begin
      rd_word = 32'h0000_0000;
      case (reg_sel(s_axi_araddr))
         3'h0: rd_word[3:0] = ctrl_a_reg;
         3'h1: rd_word[3:0] = ctrl_b_reg;
         3'h2: rd_word[2:0] = idx_reg;
         3'h3: rd_word[PORT_BITS-1:0] = port_reg;
         3'h4: rd_word[`STIU_EV_WIDTH-1:0] = stat_reg;
         3'h5: rd_word[`STIU_EV_WIDTH-1:0] = mask_reg;
         3'h6:
         begin
            rd_word[`STIU_FLG_EXT0_POS] = ext0_reg;
            rd_word[`STIU_FLG_SKIP_POS] = skip_reg;
            rd_word[`STIU_FLG_PIN_POS]  = pin_sync_reg;
            rd_word[`STIU_FLG_STBY_POS] = standby_flag;
         end
         default: rd_word = 32'h0000_0000;
      endcase
      rd_state_next = rd_state_reg;
      rdata_next    = rdata_reg;
      rresp_next    = rresp_reg;
      case (rd_state_reg)
         stiu_pkg::STIU_RD_IDLE:
         begin
            if (s_axi_arvalid)
            begin
               rd_state_next = stiu_pkg::STIU_RD_RESP;
               rdata_next    = rd_word;
               rresp_next    = (reg_sel(s_axi_araddr) == 3'h7) ? `STIU_RESP_SLVERR : `STIU_RESP_OKAY;
            end
         end
         stiu_pkg::STIU_RD_RESP:
         begin
            if (s_axi_rready)
            begin
               rd_state_next = stiu_pkg::STIU_RD_IDLE;
            end
         end
         default: rd_state_next = stiu_pkg::STIU_RD_IDLE;
      endcase
   end

   assign s_axi_arready = (rd_state_reg == stiu_pkg::STIU_RD_IDLE);
   assign s_axi_rvalid  = (rd_state_reg == stiu_pkg::STIU_RD_RESP);
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_a_reg   <= `STIU_CTRL_RESET;
         ctrl_b_reg   <= `STIU_CTRL_RESET;
         idx_reg      <= `STIU_IDX_RESET;
         port_reg     <= '0;
         stat_reg     <= '0;
         mask_reg     <= '0;
         ext0_reg     <= 1'b0;
         skip_reg     <= 1'b0;
         aw_have_reg  <= 1'b0;
         w_have_reg   <= 1'b0;
         aw_addr_reg  <= 8'h00;
         w_data_reg   <= 32'h0000_0000;
         w_strb_reg   <= 4'h0;
         bvalid_reg   <= 1'b0;
         bresp_reg    <= `STIU_RESP_OKAY;
         rd_state_reg <= stiu_pkg::STIU_RD_IDLE;
         rdata_reg    <= 32'h0000_0000;
         rresp_reg    <= `STIU_RESP_OKAY;
      end
      else
      begin
         ctrl_a_reg   <= ctrl_a_next;
         ctrl_b_reg   <= ctrl_b_next;
         idx_reg      <= idx_next;
         port_reg     <= port_next;
         stat_reg     <= stat_next;
         mask_reg     <= mask_next;
         ext0_reg     <= ext0_next;
         skip_reg     <= skip_next_val;
         aw_have_reg  <= aw_have_next;
         w_have_reg   <= w_have_next;
         aw_addr_reg  <= aw_addr_next;
         w_data_reg   <= w_data_next;
         w_strb_reg   <= w_strb_next;
         bvalid_reg   <= bvalid_next;
         bresp_reg    <= bresp_next;
         rd_state_reg <= rd_state_next;
         rdata_reg    <= rdata_next;
         rresp_reg    <= rresp_next;
      end
   end

   assign skip_next         = skip_reg;
   assign ext0_request_flag = ext0_reg;
   assign port_d_out        = port_reg;
   assign irq               = |(stat_reg & mask_reg);

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_port_one_bit: assert property (exec && instr.op == stiu_pkg::STIU_OP_SET_PORT && idx_reg < PORT_BITS
      |=> port_d_out == ($past(port_d_out) | (PORT_BITS'(1) << $past(idx_reg)))) // RQ1
      else $error("port D bit set wrong");
   a_seq_imm: assert property (exec && instr.op == stiu_pkg::STIU_OP_SEQ_IMM
      |=> skip_next == $past(instr.acc == instr.imm)) // RQ2
      else $error("immediate compare skip wrong");
   a_seq_mem: assert property (exec && instr.op == stiu_pkg::STIU_OP_SEQ_MEM
      |=> skip_next == $past(instr.acc == instr.mem)) // RQ3
      else $error("memory compare skip wrong");
   a_ext0_take: assert property (exec && instr.op == stiu_pkg::STIU_OP_TST_EXT0 && !ctrl_a_reg[0]
      && ext0_reg && !ext0_request_set |=> skip_next && !ext0_request_flag) // RQ4 RQ5
      else $error("ext0 test did not clear and skip");
   a_ext0_masked: assert property (exec && instr.op == stiu_pkg::STIU_OP_TST_EXT0 && ctrl_a_reg[0]
      |=> !skip_next && ext0_request_flag == $past(ext0_reg | ext0_request_set)) // RQ6
      else $error("masked ext0 test not a no-op");
   a_pin_low: assert property (exec && instr.op == stiu_pkg::STIU_OP_TST_PIN && !ctrl_b_reg[2]
      |=> skip_next == !$past(pin_sync_reg)) // RQ7 RQ9
      else $error("pin test low polarity wrong");
   a_pin_high: assert property (exec && instr.op == stiu_pkg::STIU_OP_TST_PIN && ctrl_b_reg[2]
      |=> skip_next == $past(pin_sync_reg)) // RQ8 RQ9
      else $error("pin test high polarity wrong");
   a_pd_test: assert property (exec && instr.op == stiu_pkg::STIU_OP_TST_PD
      |=> skip_next == $past(standby_flag)) // RQ10
      else $error("power-down test wrong");
   a_squash_quiet: assert property (instr_squash |=> !skip_next && $stable(port_d_out)) // RQ11
      else $error("skipped instruction had an effect");
   a_event_sticky: assert property (|events |=> (stat_reg & $past(events)) == $past(events))
      else $error("status bit lost its event");

   c_skip_then_squash: cover property (skip_next && instr_valid ##1 !skip_next);
   c_ext0_taken: cover property (ext0_clear);
   c_port_set: cover property (port_set ##1 $changed(port_d_out));
   c_axi_write: cover property (wr_fire ##1 s_axi_bvalid);

endmodule : stiu_unit

// *** test/stiu_seq_model.sv ***
// Sequencer stand-in that feeds instructions to the skip/test unit
`timescale 1ns/1ps

module stiu_seq_model (
   input  wire logic                aclk,
   input  wire logic                instr_squash,
   output logic                     instr_valid,
   output stiu_pkg::stiu_instr_type instr,
   output logic                     ext0_request_set
);

   initial
   begin
      instr_valid      = 1'b0;
      instr            = '0;
      ext0_request_set = 1'b0;
   end

   // One-cycle pulse; squash read at the taking edge, before that edge's updates land
   task automatic issue(input stiu_pkg::stiu_op_type op, input logic [3:0] imm, input logic [3:0] acc,
                        input logic [3:0] mem, output logic sq);
      @(posedge aclk);
      instr_valid <= 1'b1;
      instr       <= '{op, imm, acc, mem};
      @(posedge aclk);
      sq = instr_squash;
      instr_valid <= 1'b0;
      // Junk between instructions, so an idle bus is never mistaken for data
      instr       <= '{stiu_pkg::STIU_OP_SEQ_IMM, 4'hA, 4'hA, 4'hA};
      #1;
   endtask : issue

   task automatic pulse_ext0();
      @(posedge aclk);
      ext0_request_set <= 1'b1;
      @(posedge aclk);
      ext0_request_set <= 1'b0;
      #1;
   endtask : pulse_ext0

endmodule : stiu_seq_model

// *** test/stiu_unit_bench.sv ***
// Self-checking bench of the skip/test unit
`timescale 1ns/1ps
`include "stiu_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_total++; \
   $display("ERROR %0t: mismatch got %0h exp %0h", $time, g, e); end end

module stiu_unit_bench;
   logic                     aclk = 1'b0;
   logic                     aresetn = 1'b0;
   logic [7:0]               s_axi_awaddr = 8'h00;
   logic                     s_axi_awvalid = 1'b0;
   logic                     s_axi_awready;
   logic [31:0]              s_axi_wdata = 32'h0;
   logic                     s_axi_wvalid = 1'b0;
   logic                     s_axi_wready;
   logic [1:0]               s_axi_bresp;
   logic                     s_axi_bvalid;
   logic                     s_axi_bready = 1'b0;
   logic [7:0]               s_axi_araddr = 8'h00;
   logic                     s_axi_arvalid = 1'b0;
   logic                     s_axi_arready;
   logic [31:0]              s_axi_rdata;
   logic [1:0]               s_axi_rresp;
   logic                     s_axi_rvalid;
   logic                     s_axi_rready = 1'b0;
   logic                     instr_valid;
   stiu_pkg::stiu_instr_type instr;
   logic                     ext0_request_set;
   logic                     standby_flag = 1'b0;
   logic                     external_interrupt_pin = 1'b1;
   logic                     skip_next;
   logic                     instr_squash;
   logic                     ext0_request_flag;
   logic [7:0]               port_d_out;
   logic                     irq;
   int                       err_total = 0;
   int                       checks_done = 0;
   logic [1:0]               resp;
   logic [31:0]              rd;
   logic [7:0]               exp_port;

   always #2 aclk = ~aclk;

   stiu_unit #(.PORT_BITS(8)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .instr_valid(instr_valid), .instr(instr),
      .ext0_request_set(ext0_request_set), .standby_flag(standby_flag),
      .external_interrupt_pin(external_interrupt_pin), .skip_next(skip_next), .instr_squash(instr_squash),
      .ext0_request_flag(ext0_request_flag), .port_d_out(port_d_out), .irq(irq));

   stiu_seq_model seq (.aclk(aclk), .instr_squash(instr_squash), .instr_valid(instr_valid), .instr(instr),
      .ext0_request_set(ext0_request_set));

   // Handshakes read at the rising edge itself, so a taken item is released at its own edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic b_ok;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      b_ok = 1'b0;
      while (!b_ok)
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         b_ok = s_axi_bvalid && s_axi_bready;
         if (b_ok) r = s_axi_bresp;
      end
      s_axi_bready <= 1'b0;
      #1;
   endtask : axi_wr

   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic r_ok;
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      r_ok = 1'b0;
      while (!r_ok)
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         r_ok = s_axi_rvalid && s_axi_rready;
         if (r_ok) d = s_axi_rdata;
         if (r_ok) r = s_axi_rresp;
      end
      s_axi_rready <= 1'b0;
      #1;
   endtask : axi_rd

   // Test instruction, then a follower that must be squashed exactly when a skip was taken
   task automatic run(input stiu_pkg::stiu_op_type op, input logic [3:0] imm, input logic [3:0] acc,
                      input logic [3:0] mem, input logic exp);
      logic sq;
      seq.issue(op, imm, acc, mem, sq);
      `CHK(skip_next, exp)
      seq.issue(stiu_pkg::STIU_OP_NONE, 4'h0, 4'h0, 4'h0, sq);
      `CHK(sq, exp)
      `CHK(skip_next, 1'b0)
   endtask : run

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   initial
   begin
      #200000;
      err_total++;
      print_verdict();
   end

   initial
   begin
      logic sq;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      `CHK({port_d_out, irq, skip_next, ext0_request_flag}, 11'h000)
      $display("test reset done");
      seq.issue(stiu_pkg::STIU_OP_SEQ_IMM, 4'h9, 4'h9, 4'h0, sq);
      seq.issue(stiu_pkg::STIU_OP_SET_PORT, 4'h0, 4'h0, 4'h0, sq);
      `CHK(sq, 1'b1)
      `CHK(port_d_out, 8'h00)
      $display("test squash done");
      exp_port = 8'h00;
      for (int i = 0; i < 8; i++)
      begin
         axi_wr(`STIU_ADDR_PORT_IDX, 32'(i), resp);
         seq.issue(stiu_pkg::STIU_OP_SET_PORT, 4'h0, 4'h0, 4'h0, sq);
         exp_port[i] = 1'b1;
         `CHK(port_d_out, exp_port)
      end
      axi_rd(`STIU_ADDR_PORT_D, rd, resp);
      `CHK(rd, 32'h0000_00FF)
      $display("test port done");
      for (int n = 0; n < 16; n++)
         run(stiu_pkg::STIU_OP_SEQ_IMM, 4'(n), 4'h6, 4'h0, n == 6);
      run(stiu_pkg::STIU_OP_SEQ_MEM, 4'h0, 4'hC, 4'hC, 1'b1);
      run(stiu_pkg::STIU_OP_SEQ_MEM, 4'hC, 4'hC, 4'h4, 1'b0);
      $display("test compare done");
      seq.pulse_ext0();
      axi_wr(`STIU_ADDR_CTRL_A, 32'h0000_0001, resp);
      run(stiu_pkg::STIU_OP_TST_EXT0, 4'h0, 4'h0, 4'h0, 1'b0);
      `CHK(ext0_request_flag, 1'b1)
      axi_wr(`STIU_ADDR_CTRL_A, 32'h0000_000E, resp);
      run(stiu_pkg::STIU_OP_TST_EXT0, 4'h0, 4'h0, 4'h0, 1'b1);
      `CHK(ext0_request_flag, 1'b0)
      run(stiu_pkg::STIU_OP_TST_EXT0, 4'h0, 4'h0, 4'h0, 1'b0);
      $display("test ext0 done");
      for (int p = 0; p < 4; p++)
      begin
         axi_wr(`STIU_ADDR_CTRL_B, (p[1] ? 32'h0000_0004 : 32'h0000_000B), resp);
         external_interrupt_pin <= p[0];
         repeat (3) @(posedge aclk);
         run(stiu_pkg::STIU_OP_TST_PIN, 4'h0, 4'h0, 4'h0, p[0] == p[1]);
      end
      $display("test pin done");
      for (int s = 0; s < 2; s++)
      begin
         @(posedge aclk);
         standby_flag <= s[0];
         run(stiu_pkg::STIU_OP_TST_PD, 4'h0, 4'h0, 4'h0, s[0]);
      end
      $display("test standby done");
      axi_rd(`STIU_ADDR_IRQ_STAT, rd, resp);
      `CHK(rd, 32'h0000_0007)
      `CHK(irq, 1'b0)
      axi_wr(`STIU_ADDR_IRQ_MASK, 32'h0000_0002, resp);
      `CHK(irq, 1'b1)
      axi_wr(`STIU_ADDR_IRQ_STAT, 32'h0000_0002, resp);
      `CHK(irq, 1'b0)
      axi_rd(`STIU_ADDR_IRQ_STAT, rd, resp);
      `CHK(rd, 32'h0000_0005)
      axi_rd(`STIU_ADDR_CTRL_A, rd, resp);
      `CHK(rd, 32'h0000_000E)
      axi_rd(`STIU_ADDR_CTRL_B, rd, resp);
      `CHK(rd, 32'h0000_0004)
      axi_rd(`STIU_ADDR_FLAGS, rd, resp);
      `CHK(rd, 32'h0000_000C)
      axi_wr(`STIU_ADDR_PORT_D, 32'h0000_0000, resp);
      `CHK({resp, port_d_out}, {`STIU_RESP_OKAY, 8'hFF})
      axi_wr(8'h40, 32'h0000_0001, resp);
      `CHK(resp, `STIU_RESP_SLVERR)
      axi_rd(8'h40, rd, resp);
      `CHK({resp, rd}, {`STIU_RESP_SLVERR, 32'h0})
      $display("test registers done");
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      #1;
      `CHK({port_d_out, irq, skip_next, ext0_request_flag}, 11'h000)
      $display("test mid reset done");
      print_verdict();
   end

endmodule : stiu_unit_bench
